// ### verilog/cpl_defines.vh
// Constants for the two-channel protection sequencer.
// Assumes a 125 MHz system clock.
`ifndef CPL_DEFINES_VH
`define CPL_DEFINES_VH
`define CPL_CLK_MHZ        125
`define CPL_TICK_DIV       8'h7c
`define CPL_FAULT_US       8'h64
`define CPL_OFF_FAST_US    8'h1e
`define CPL_OFF_SLOW_US    8'h64
`define CPL_TMR_W          8
`define CPL_SEL_PIN        2'h0
`define CPL_SEL_BIT        2'h1
`define CPL_SEL_OR         2'h2
`define CPL_SEL_AND        2'h3
`endif

// ### verilog/cpl_tick.v
// Divider producing a one-cycle pulse every microsecond.
// Assumes the single 125 MHz system clock.
`timescale 1ns/1ns
`include "cpl_defines.vh"
module cpl_tick (
  // Clock and reset
  input  wire clk,
  input  wire rst,
  // Microsecond enable
  output reg  tick
);
  reg [7:0] cnt;
  always @(posedge clk) begin
    if (rst) begin
      cnt  <= 8'h00;
      tick <= 1'b0;
    end else if (cnt == `CPL_TICK_DIV) begin
      cnt  <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule

// ### verilog/cpl_filter.v
// Persistence timer counting microsecond ticks while a condition holds.
// Assumes tick is a one-cycle enable from the divider.
`timescale 1ns/1ns
`include "cpl_defines.vh"
module cpl_filter (
  // Clock, reset and microsecond tick
  input  wire                  clk,
  input  wire                  rst,
  input  wire                  tick,
  // Condition and limit
  input  wire                  cond,
  input  wire [`CPL_TMR_W-1:0] limit,
  // Condition persisted for the limit
  output wire                  done
);
  reg [`CPL_TMR_W-1:0] cnt;
  assign done = cond && (cnt >= limit);
  // Short glitches restart the count, so they are never reported.
  always @(posedge clk) begin
    if (rst || !cond) begin
      cnt <= {`CPL_TMR_W{1'b0}};
    end else if (tick && !done) begin
      cnt <= cnt + {{(`CPL_TMR_W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ### verilog/cpl_top.v
// Two-channel protection sequencer: overload, over-temperature, flags.
// Assumes comparator and sensor inputs are synchronous to CLK.
// Functional notes
// - Current-limit mode keeps channel on, flags overload after filter time.
// - In current-limit mode, status-pin diagnosis drops overload indication when overload vanishes.
// - Serial diagnosis latches overload until chip-select rise after good transfer.
// - Shutdown mode switches channel off and flags after shutdown delay.
// - Shutdown latch holds channel off until commanded off by pin or bit.
// - Shutdown delay depends on the channel slew selection.
// - Shutdown mode overload flag clears on transfer only with input pin low.
// - Over-temperature switches channel off and flags at once, no filter.
// - Status-pin diagnosis drops over-temperature indication when it ends.
// - Serial diagnosis latches over-temperature until chip-select rise.
// - Automatic restart turns channel on when sensor reports cooled.
// - Latching restart keeps channel off until commanded off first.
// - Latching mode clears over-temperature flag on transfer only after channel commanded off.
// - Over-temperature shutdown applies in both overload modes.
// - Reverse-current operation generates no overload or over-temperature flags.
// - On state from pin, bit, OR or AND; defaults to pin only.
// - Overloads shorter than the active filter or shutdown delay are neither latched nor reported.
// - Overload and over-temperature flags merge into one protection flag.
// - Shutdown delay within 10-50 us fast slew, 10-150 us slow.
`timescale 1ns/1ns
`include "cpl_defines.vh"
module cpl_top (
  // Clock and reset
  input  wire       CLK,
  input  wire       SYS_RST,
  // Controller side
  input  wire [1:0] CHANNEL_INPUT,
  input  wire [1:0] CHANNEL_COMMAND_BIT,
  input  wire [1:0] INPUT_COMBINE_SELECT,
  input  wire [1:0] SLEW_SELECT,
  input  wire [1:0] SHUTDOWN_MODE,
  input  wire [1:0] LATCH_RESTART,
  input  wire       SERIAL_DIAG,
  input  wire       CS_RISE_GOOD,
  // Analog side
  input  wire [1:0] OVERLOAD_DETECT,
  input  wire [1:0] OVERTEMP_HOT,
  input  wire [1:0] REVERSE_CURRENT,
  // Outputs
  output reg  [1:0] CHANNEL_ON,
  output reg  [1:0] OVERLOAD_FLAG,
  output reg  [1:0] OVERTEMP_FLAG,
  output reg  [1:0] PROTECTION_SUMMARY_FLAG,
  output reg  [1:0] OVERLOAD_LATCH_FLAG,
  output reg  [1:0] STATUS_PIN
);
  wire tick;
  cpl_tick u_tick (
    .clk  (CLK),
    .rst  (SYS_RST),
    .tick (tick)
  );

  localparam [`CPL_TMR_W-1:0] FAULT_CNT = `CPL_FAULT_US;
  localparam [`CPL_TMR_W-1:0] OFF_FAST  = `CPL_OFF_FAST_US;
  localparam [`CPL_TMR_W-1:0] OFF_SLOW  = `CPL_OFF_SLOW_US;

  genvar n;
  generate
    for (n = 0; n < 2; n = n + 1) begin : g_ch
      reg  cmd;
      reg  ol_latch;
      reg  ot_latch;
      reg  ol_flag;
      reg  ot_flag;
      reg  next_ol_flag;
      reg  next_ot_flag;
      wire ol_done;
      wire sel_slow = SLEW_SELECT[n];
      wire [`CPL_TMR_W-1:0] ol_limit;
      wire ol_cond;
      wire rev = REVERSE_CURRENT[n];
      wire hot = OVERTEMP_HOT[n] && !rev;
      wire cmd_off;

      always @* begin
        case (INPUT_COMBINE_SELECT)
          `CPL_SEL_PIN: cmd = CHANNEL_INPUT[n];
          `CPL_SEL_BIT: cmd = CHANNEL_COMMAND_BIT[n];
          `CPL_SEL_OR:  cmd = CHANNEL_INPUT[n] | CHANNEL_COMMAND_BIT[n];
          default:      cmd = CHANNEL_INPUT[n] & CHANNEL_COMMAND_BIT[n];
        endcase
      end
      assign cmd_off = !cmd;

      // Detection is gated by the command, so a commanded-off channel cannot time out.
      assign ol_cond  = OVERLOAD_DETECT[n] && !rev && cmd && !ol_latch;
      // Slow slew gets the longer switch-off delay.
      assign ol_limit = SHUTDOWN_MODE[n] ? (sel_slow ? OFF_SLOW : OFF_FAST) : FAULT_CNT;

      cpl_filter u_ol (
        .clk   (CLK),
        .rst   (SYS_RST),
        .tick  (tick),
        .cond  (ol_cond),
        .limit (ol_limit),
        .done  (ol_done)
      );

      always @* begin
        next_ol_flag = ol_flag;
        next_ot_flag = ot_flag;
        if (CS_RISE_GOOD) begin
          if (!SHUTDOWN_MODE[n] || !CHANNEL_INPUT[n]) begin
            next_ol_flag = 1'b0;
          end
          if (!LATCH_RESTART[n] || ot_latch == 1'b0 || cmd_off) begin
            next_ot_flag = 1'b0;
          end
        end
        // Set wins over a clear arriving in the same cycle.
        if (ol_done || (ol_latch && SHUTDOWN_MODE[n])) begin
          next_ol_flag = 1'b1;
        end
        if (hot) begin
          next_ot_flag = 1'b1;
        end
      end

      always @(posedge CLK) begin
        if (SYS_RST) begin
          ol_latch <= 1'b0;
          ot_latch <= 1'b0;
          ol_flag  <= 1'b0;
          ot_flag  <= 1'b0;
        end else begin
          if (cmd_off) begin
            ol_latch <= 1'b0;
          end else if (ol_done && SHUTDOWN_MODE[n]) begin
            ol_latch <= 1'b1;
          end
          if (hot) begin
            ot_latch <= 1'b1;
          end else if (!LATCH_RESTART[n] || cmd_off) begin
            ot_latch <= 1'b0;
          end
          ol_flag <= next_ol_flag;
          ot_flag <= next_ot_flag;
        end
      end

      always @(posedge CLK) begin
        if (SYS_RST) begin
          CHANNEL_ON[n]              <= 1'b0;
          OVERLOAD_FLAG[n]           <= 1'b0;
          OVERTEMP_FLAG[n]           <= 1'b0;
          PROTECTION_SUMMARY_FLAG[n] <= 1'b0;
          OVERLOAD_LATCH_FLAG[n]     <= 1'b0;
          STATUS_PIN[n]              <= 1'b0;
        end else begin
          // Over-temperature off is immediate: sensor gates the output directly.
          CHANNEL_ON[n] <= cmd && !hot && !ot_latch && !ol_latch;
          OVERLOAD_LATCH_FLAG[n] <= ol_latch;
          if (SERIAL_DIAG) begin
            OVERLOAD_FLAG[n]           <= next_ol_flag;
            OVERTEMP_FLAG[n]           <= next_ot_flag;
            PROTECTION_SUMMARY_FLAG[n] <= next_ol_flag | next_ot_flag;
            STATUS_PIN[n]              <= cmd;
          end else begin
            OVERLOAD_FLAG[n]           <= ol_done || ol_latch;
            OVERTEMP_FLAG[n]           <= hot;
            PROTECTION_SUMMARY_FLAG[n] <= ol_done || ol_latch || hot;
            STATUS_PIN[n]              <= (ol_done || ol_latch || hot) ? !cmd : cmd;
          end
        end
      end
    end
  endgenerate
endmodule

// ### sim/cpl_ctrl_model.sv
// Controller model driving the parallel input pins and the chip-select pulse.
// Assumes bench requests change at the rising clock edge.
`timescale 1ns/1ns
module cpl_ctrl_model (
  input  wire       clk,
  input  wire [1:0] want_on,
  input  wire       clear_req,
  output reg  [1:0] pin,
  output reg        cs_rise
);
  initial pin = 2'h0;
  initial cs_rise = 1'b0;
  // A restart after an overload shutdown or latched over-temperature is only asked for by taking the pin low first.
  always @(posedge clk) begin
    pin <= want_on;
    cs_rise <= clear_req;
  end
endmodule

// ### sim/cpl_top_asserts.sv
// Checker for the protection sequencer, watching channel 0; the summary check covers both channels.
// Bound to cpl_top; sees only its ports.
`timescale 1ns/1ns
module cpl_top_asserts (
  input wire       CLK,
  input wire       SYS_RST,
  input wire [1:0] CHANNEL_INPUT,
  input wire [1:0] INPUT_COMBINE_SELECT,
  input wire [1:0] SHUTDOWN_MODE,
  input wire       SERIAL_DIAG,
  input wire       CS_RISE_GOOD,
  input wire [1:0] OVERLOAD_DETECT,
  input wire [1:0] OVERTEMP_HOT,
  input wire [1:0] REVERSE_CURRENT,
  input wire [1:0] CHANNEL_ON,
  input wire [1:0] OVERLOAD_FLAG,
  input wire [1:0] OVERTEMP_FLAG,
  input wire [1:0] PROTECTION_SUMMARY_FLAG,
  input wire [1:0] OVERLOAD_LATCH_FLAG
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_ot_off_now: assert property (OVERTEMP_HOT[0] && !REVERSE_CURRENT[0] |=> !CHANNEL_ON[0] && OVERTEMP_FLAG[0])
    else $error("overtemp not acted on");
  a_summary_or: assert property (PROTECTION_SUMMARY_FLAG == (OVERLOAD_FLAG | OVERTEMP_FLAG))
    else $error("summary flag wrong");
  a_rev_no_flag: assert property ($rose(OVERTEMP_FLAG[0]) |-> !$past(REVERSE_CURRENT[0]))
    else $error("flag during reverse current");
  a_pin_ot_drop: assert property (!SERIAL_DIAG && !OVERTEMP_HOT[0] |=> !OVERTEMP_FLAG[0])
    else $error("overtemp flag held");
  a_ol_filtered: assert property ($rose(OVERLOAD_FLAG[0]) |-> $past(OVERLOAD_DETECT[0], 8))
    else $error("short overload flagged");
  a_cl_keep_on: assert property (!SHUTDOWN_MODE[0] && CHANNEL_ON[0] && CHANNEL_INPUT[0] && INPUT_COMBINE_SELECT == 2'h0
    && !OVERTEMP_HOT[0] |=> CHANNEL_ON[0]) else $error("limit mode switched off");
  a_latch_off: assert property (OVERLOAD_LATCH_FLAG[0] && INPUT_COMBINE_SELECT == 2'h0 |=> !CHANNEL_ON[0])
    else $error("latched channel on");
  a_ser_ol_clear: assert property ($fell(OVERLOAD_FLAG[0]) && $past(SERIAL_DIAG) && !$past(SYS_RST)
    |-> $past(CS_RISE_GOOD)) else $error("serial overload flag lost");
  cover property (OVERLOAD_LATCH_FLAG[0]);
  cover property ($rose(OVERLOAD_FLAG[0]));
  cover property ($fell(OVERTEMP_FLAG[0]) && SERIAL_DIAG);
endmodule
bind cpl_top cpl_top_asserts chk (.*);

// ### sim/test_channel_protection_logic.sv
// Testbench for the protection sequencer, channel 0 faulted, channel 1 idle on.
// Assumes the controller model drives pins and chip-select.
`timescale 1ns/1ns
module test_channel_protection_logic;
  reg        clk, rst, sd, clr;
  reg  [1:0] want, cmd, sel, slew, mode, lr, ol, hot, rev, got;
  wire [1:0] pin, on, olf, otf, psf, latf, stp;
  wire       cs;
  integer    mismatches, samples_checked, i;
  cpl_ctrl_model ctl (.clk(clk), .want_on(want), .clear_req(clr), .pin(pin), .cs_rise(cs));
  cpl_top uut (.CLK(clk), .SYS_RST(rst), .CHANNEL_INPUT(pin), .CHANNEL_COMMAND_BIT(cmd),
    .INPUT_COMBINE_SELECT(sel), .SLEW_SELECT(slew), .SHUTDOWN_MODE(mode), .LATCH_RESTART(lr),
    .SERIAL_DIAG(sd), .CS_RISE_GOOD(cs), .OVERLOAD_DETECT(ol), .OVERTEMP_HOT(hot),
    .REVERSE_CURRENT(rev), .CHANNEL_ON(on), .OVERLOAD_FLAG(olf), .OVERTEMP_FLAG(otf),
    .PROTECTION_SUMMARY_FLAG(psf), .OVERLOAD_LATCH_FLAG(latf), .STATUS_PIN(stp));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task w(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task us(input integer n);
    w(n * 125);
  endtask
  // Sampled at the falling edge so the outputs have settled.
  task chk(input integer k, input [1:0] exp);
    @(negedge clk);
    got = (k == 0) ? on : (k == 1) ? olf : (k == 2) ? otf : (k == 3) ? psf : (k == 4) ? latf : stp;
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("MISMATCH %0t output %0d got %b expected %b", $time, k, got, exp);
    end
    @(posedge clk);
  endtask
  task cs_pulse;
    clr <= 1'b1;
    w(1);
    clr <= 1'b0;
    w(3);
  endtask
  task complete_run;
    $display("Comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    us(700);
    mismatches = mismatches + 1;
    complete_run;
  end
  initial begin
    mismatches = 0;
    samples_checked = 0;
    {rst, sd, clr, want, cmd, sel, slew, mode, lr, ol, hot, rev} = 21'h100000;
    w(4);
    rst <= 1'b0;
    want <= 2'h3;
    for (i = 0; i < 4; i = i + 1) begin
      sel <= i[1:0];
      w(3);
      chk(0, (i % 2) ? 2'h0 : 2'h3);
    end
    sel <= 2'h0;
    hot <= 2'h1;
    w(2);
    chk(0, 2'h2);
    chk(3, 2'h1);
    hot <= 2'h0;
    w(2);
    chk(2, 2'h0);
    chk(0, 2'h3);
    ol <= 2'h1;
    us(50);
    ol <= 2'h0;
    chk(1, 2'h0);
    ol <= 2'h1;
    us(110);
    chk(1, 2'h1);
    chk(0, 2'h3);
    chk(5, 2'h2);
    ol <= 2'h0;
    w(3);
    chk(1, 2'h0);
    chk(5, 2'h3);
    // Flush flags latched internally during pin diagnosis before going serial.
    cs_pulse;
    sd <= 1'b1;
    ol <= 2'h1;
    us(110);
    ol <= 2'h0;
    w(3);
    chk(1, 2'h1);
    cs_pulse;
    chk(1, 2'h0);
    hot <= 2'h1;
    w(2);
    hot <= 2'h0;
    w(3);
    chk(2, 2'h1);
    cs_pulse;
    chk(2, 2'h0);
    mode <= 2'h1;
    ol <= 2'h1;
    us(20);
    chk(0, 2'h3);
    us(20);
    chk(0, 2'h2);
    ol <= 2'h0;
    cs_pulse;
    chk(1, 2'h1);
    chk(4, 2'h1);
    want <= 2'h2;
    w(3);
    cs_pulse;
    chk(1, 2'h0);
    want <= 2'h3;
    slew <= 2'h1;
    ol <= 2'h1;
    us(40);
    chk(0, 2'h3);
    us(70);
    chk(0, 2'h2);
    ol <= 2'h0;
    want <= 2'h2;
    w(3);
    want <= 2'h3;
    lr <= 2'h1;
    hot <= 2'h1;
    w(2);
    hot <= 2'h0;
    w(3);
    chk(0, 2'h2);
    cs_pulse;
    chk(2, 2'h1);
    want <= 2'h2;
    w(3);
    cs_pulse;
    chk(2, 2'h0);
    want <= 2'h3;
    w(3);
    chk(0, 2'h3);
    rev <= 2'h1;
    hot <= 2'h1;
    w(3);
    chk(2, 2'h0);
    complete_run;
  end
endmodule
